// File: include/cam_pkg.sv
// Shared constants and types for the charge accumulation and power mode block.
// Assumes a 10 MHz pclk and an APB register port with 32-bit data.
`default_nettype none

package cam_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned HALF_SEC_MS = 500;
  localparam int unsigned HALF_SEC_CYCLES_DEF = HALF_SEC_MS * 1000 * CLK_MHZ;
  localparam int unsigned SHELF_DELAY_US = 100;
  localparam int unsigned WAKE_DELAY_US = 100;
  localparam int unsigned SHELF_DELAY_CYCLES = SHELF_DELAY_US * CLK_MHZ;
  localparam int unsigned WAKE_DELAY_CYCLES = WAKE_DELAY_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_ACC_CTRL = 12'h000;
  localparam logic [11:0] OFS_CONV_CFG = 12'h004;
  localparam logic [11:0] OFS_OP_MODE = 12'h008;
  localparam logic [11:0] OFS_TRIP_CTRL = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_CHG_ACC = 12'h014;
  localparam logic [11:0] OFS_DIS_ACC = 12'h018;
  localparam logic [11:0] OFS_CHG_TIME = 12'h01C;
  localparam logic [11:0] OFS_DIS_TIME = 12'h020;
  localparam logic [11:0] OFS_TEMP_ACC = 12'h024;
  localparam logic [11:0] OFS_CELL2_ACC = 12'h028;
  localparam logic [11:0] OFS_TEMP_TIME = 12'h02C;
  localparam logic [11:0] OFS_CELL2_TIME = 12'h030;
  localparam logic [9:0] LAST_INDEX = 10'h00C;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int ACC_EN_BIT = 0;
  localparam int ACC_TEMP_BIT = 1;
  localparam int ACC_VOLT_BIT = 2;
  localparam int ACC_TSEL_BIT = 3;
  localparam int CFG_SAMP_BIT = 0;
  localparam int CFG_DIV_LSB = 1;
  localparam int OPM_SLEEP_SAMPLE_BIT_BIT = 0;
  localparam int OPM_DIV_LSB = 1;
  localparam logic [3:0] ACC_CTRL_RST = 4'h0;
  localparam logic [3:0] CONV_CFG_RST = 4'h0;
  localparam logic [2:0] SLEEP_DIV_RST = 3'h0;
  localparam logic [5:0] TRIP_CTRL_RST = 6'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CAM_OFF = 3'b000,
    CAM_RUN = 3'b001,
    CAM_SAMPLE = 3'b010,
    CAM_SSLEEP = 3'b011,
    CAM_SHELF = 3'b100
  } cam_mode_t;

  // Sign-magnitude conversion results from the converter
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] internal_temp_result;
    logic [15:0] external_temp_result;
    logic [15:0] second_cell_result;
  } cam_results_t;

  // Analog comparator outputs, synchronous to pclk
  typedef struct packed {
    logic pack_above_por;
    logic first_cell_below_trip;
    logic second_cell_below_trip;
    logic charge_above_trip;
    logic current_below_low_trip;
    logic pack_above_sleep_trip;
    logic pack_below_pack_trip;
  } cam_trips_t;

  // Trip control fields
  typedef struct packed {
    logic shelf_entry_enable;
    logic pack_wake_enable;
    logic low_current_entry_enable;
    logic charge_wake_enable;
    logic second_cell_entry_enable;
    logic first_cell_entry_enable;
  } cam_trip_ctrl_t;

endpackage : cam_pkg

`default_nettype wire

// File: verilog/cam_top.sv
// Charge/discharge accumulation, general accumulators and power mode sequencing.
// Assumes all inputs except presetn are synchronous to pclk; converter and comparators sit outside.
//
// The placing of the registers and register access over APB are this design's own decisions.
`default_nettype none

module cam_top
  import cam_pkg::*;
#(
  parameter int unsigned HALF_SEC_CYCLES = cam_pkg::HALF_SEC_CYCLES_DEF
)(
  input wire logic pclk, // Primary clock, 10 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire cam_pkg::cam_results_t results, // Latest conversion results
  input wire cam_pkg::cam_trips_t trips, // Comparator levels
  input wire logic conv_done, // Conversion set finished, one-cycle pulse
  input wire logic rc_half_tick, // Half-second tick of the sleep RC oscillator
  input wire logic scl_in, // Two-wire clock line level
  input wire logic sda_in, // Two-wire data line level
  output logic conv_start, // Start one conversion set, one-cycle pulse
  output logic analog_on, // Analog circuitry powered
  output logic temp_select_ext, // Temperature source for the converter
  output cam_pkg::cam_mode_t mode // Current power mode
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // Zero-extended magnitude of a sign-magnitude result
  function automatic logic [31:0] magnitude(input logic [15:0] r);
    magnitude = {17'h00000, r[14:0]};
  endfunction : magnitude

  // Number of half-second ticks for a divider exponent
  function automatic logic [14:0] interval_len(input logic [3:0] e);
    interval_len = 15'h0001 << e;
  endfunction : interval_len

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [3:0] acc_ctrl_q;
  logic [3:0] conv_cfg_q;
  logic [2:0] sleep_div_q;
  logic sleep_q;
  cam_trip_ctrl_t trip_ctrl_q;
  cam_mode_t mode_q;
  cam_mode_t mode_d;
  logic shelf_q;
  logic [15:0] line_cnt_q;
  logic [22:0] half_cnt_q;
  logic [14:0] int_cnt_q;
  logic pending_q;
  logic busy_q;
  logic [31:0] chg_acc_q;
  logic [31:0] dis_acc_q;
  logic [31:0] chg_time_q;
  logic [31:0] dis_time_q;
  logic [31:0] temp_acc_q;
  logic [31:0] cell2_acc_q;
  logic [31:0] temp_time_q;
  logic [31:0] cell2_time_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic conv_start_q;
  logic analog_on_q;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------

  // Access phase answered one cycle after it begins
  wire access_first = psel & penable & ~pready_q;
  wire access_done = psel & penable & pready_q;
  wire [9:0] reg_index = paddr[11:2];
  wire addr_ok = (paddr[1:0] == 2'b00) && (reg_index <= LAST_INDEX);
  wire bus_live = (mode_q != CAM_SHELF);
  wire wr_fire = access_done & pwrite & bus_live & addr_ok;
  wire wr_acc = wr_fire && (paddr == OFS_ACC_CTRL);
  wire wr_cfg = wr_fire && (paddr == OFS_CONV_CFG);
  wire wr_opm = wr_fire && (paddr == OFS_OP_MODE);
  wire wr_trip = wr_fire && (paddr == OFS_TRIP_CTRL);

  // Read words by index
  wire [31:0] rd_words [0:12];
  assign rd_words[0] = {28'h0000000, acc_ctrl_q};
  assign rd_words[1] = {28'h0000000, conv_cfg_q};
  assign rd_words[2] = {28'h0000000, sleep_div_q, sleep_q};
  assign rd_words[3] = {26'h0000000, trip_ctrl_q};
  assign rd_words[4] = {27'h0000000, busy_q, 1'b0, mode_q};
  assign rd_words[5] = chg_acc_q;
  assign rd_words[6] = dis_acc_q;
  assign rd_words[7] = chg_time_q;
  assign rd_words[8] = dis_time_q;
  assign rd_words[9] = temp_acc_q;
  assign rd_words[10] = cell2_acc_q;
  assign rd_words[11] = temp_time_q;
  assign rd_words[12] = cell2_time_q;
  wire [31:0] rd_value = (addr_ok && bus_live) ? rd_words[reg_index[3:0]] : 32'h00000000;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  wire acc_en = acc_ctrl_q[ACC_EN_BIT];
  wire temp_en = acc_ctrl_q[ACC_TEMP_BIT];
  wire volt_en = acc_ctrl_q[ACC_VOLT_BIT];
  wire tsel_ext = acc_ctrl_q[ACC_TSEL_BIT];
  wire samp_bit = conv_cfg_q[CFG_SAMP_BIT];
  wire [2:0] samp_div = conv_cfg_q[CFG_DIV_LSB +: 3];

  // ---------------------------------------------------------------
  // Sample-sleep entry and wake
  // ---------------------------------------------------------------

  // Charge wake condition blocks cell-trip entry
  wire charge_wake = trip_ctrl_q.charge_wake_enable & trips.charge_above_trip;
  wire pack_wake = trip_ctrl_q.pack_wake_enable & trips.pack_above_sleep_trip;
  wire cell_trip = (trip_ctrl_q.first_cell_entry_enable & trips.first_cell_below_trip)
                 | (trip_ctrl_q.second_cell_entry_enable & trips.second_cell_below_trip);
  wire cell_entry = cell_trip & ~charge_wake;
  wire low_cur_entry = trip_ctrl_q.low_current_entry_enable & trips.current_below_low_trip;
  wire awake_mode = (mode_q == CAM_RUN) || (mode_q == CAM_SAMPLE);
  wire sleep_entry = awake_mode & (cell_entry | low_cur_entry);
  wire sleep_wake = sleep_q & (mode_q == CAM_SSLEEP) & (charge_wake | pack_wake);

  // Hardware wake clears, hardware entry sets over a host clear, else host write
  wire sleep_d = sleep_wake ? 1'b0
               : sleep_entry ? 1'b1
               : wr_opm ? pwdata[OPM_SLEEP_SAMPLE_BIT_BIT]
               : sleep_q;

  // ---------------------------------------------------------------
  // Shelf-sleep arming and bus-line watch
  // ---------------------------------------------------------------
  wire shelf_armed = trip_ctrl_q.shelf_entry_enable | trips.pack_below_pack_trip;
  wire lines_low = ~scl_in & ~sda_in;
  wire lines_high = scl_in & sda_in;
  wire line_hit = shelf_q ? lines_high : (lines_low & shelf_armed & (mode_q != CAM_OFF));
  wire [15:0] line_goal = shelf_q ? 16'(WAKE_DELAY_CYCLES - 1) : 16'(SHELF_DELAY_CYCLES - 1);
  wire line_expired = line_hit && (line_cnt_q == line_goal);

  // ---------------------------------------------------------------
  // Mode selection
  // ---------------------------------------------------------------

  // Shelf over sample-sleep over sample over run
  assign mode_d = ~trips.pack_above_por ? CAM_OFF
                : shelf_q ? CAM_SHELF
                : sleep_q ? CAM_SSLEEP
                : samp_bit ? CAM_SAMPLE
                : CAM_RUN;

  // ---------------------------------------------------------------
  // Interval timing
  // ---------------------------------------------------------------

  // Sleep intervals run on the RC tick, sample intervals on the primary tick
  wire half_tick = (half_cnt_q == 23'(HALF_SEC_CYCLES - 1));
  wire in_sample = (mode_q == CAM_SAMPLE);
  wire in_sleep = (mode_q == CAM_SSLEEP);
  wire interval_tick = in_sleep ? rc_half_tick : (in_sample & half_tick);
  wire [3:0] interval_exp = in_sleep ? ({1'b0, samp_div} + {1'b0, sleep_div_q}) : {1'b0, samp_div};
  wire [14:0] interval_goal = interval_len(interval_exp) - 15'h0001;
  wire interval_fire = interval_tick && (int_cnt_q == interval_goal);
  wire mode_change = (mode_d != mode_q);

  // Run starts back to back; sample modes start when the interval ends
  wire start_now = ~busy_q & ~mode_change & ((mode_q == CAM_RUN)
                 | ((in_sample | in_sleep) & (pending_q | interval_fire)));

  // ---------------------------------------------------------------
  // Accumulation decode
  // ---------------------------------------------------------------
  wire update = conv_done & busy_q & (mode_q != CAM_SHELF) & (mode_q != CAM_OFF);
  wire cur_charge = ~results.current[15];
  wire chg_upd = update & acc_en & cur_charge;
  wire dis_upd = update & acc_en & ~cur_charge;
  wire temp_upd = update & acc_en & temp_en;
  wire cell2_upd = update & acc_en & volt_en;
  wire [15:0] temp_src = tsel_ext ? results.external_temp_result : results.internal_temp_result;

  // ---------------------------------------------------------------
  // APB slave registers
  // ---------------------------------------------------------------

  // Ready, read data and error settle one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      pready_q <= access_first;
      prdata_q <= access_first ? rd_value : 32'h00000000;
      pslverr_q <= access_first & ~addr_ok;
    end
  end

  // Software-written control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_ctrl_q <= ACC_CTRL_RST;
      conv_cfg_q <= CONV_CFG_RST;
      sleep_div_q <= SLEEP_DIV_RST;
      trip_ctrl_q <= TRIP_CTRL_RST;
      sleep_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_acc)
        acc_ctrl_q <= pwdata[3:0];
      if (wr_cfg)
        conv_cfg_q <= pwdata[3:0];
      if (wr_opm)
        sleep_div_q <= pwdata[OPM_DIV_LSB +: 3];
      if (wr_trip)
        trip_ctrl_q <= pwdata[5:0];
      sleep_q <= sleep_d;
    end
  end

  // ---------------------------------------------------------------
  // Mode and shelf sequencing
  // ---------------------------------------------------------------

  // Line counter times both-low for entry and both-high for exit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= CAM_OFF;
      shelf_q <= 1'b0;
      line_cnt_q <= 16'h0000;
    end
    else if (ce)
    begin
      mode_q <= mode_d;
      if (!trips.pack_above_por)
      begin
        shelf_q <= 1'b0;
        line_cnt_q <= 16'h0000;
      end
      else if (line_expired)
      begin
        shelf_q <= ~shelf_q;
        line_cnt_q <= 16'h0000;
      end
      else if (line_hit)
        line_cnt_q <= line_cnt_q + 16'h0001;
      else
        line_cnt_q <= 16'h0000;
    end
  end

  // Half-second base and interval counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_cnt_q <= 23'h000000;
      int_cnt_q <= 15'h0000;
      pending_q <= 1'b0;
    end
    else if (ce)
    begin
      half_cnt_q <= (half_tick || mode_change) ? 23'h000000 : half_cnt_q + 23'h000001;
      if (mode_change || interval_fire)
        int_cnt_q <= 15'h0000;
      else if (interval_tick)
        int_cnt_q <= int_cnt_q + 15'h0001;
      pending_q <= ~mode_change & ~start_now & (pending_q | interval_fire);
    end
  end

  // Conversion request and analog power
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      conv_start_q <= 1'b0;
      analog_on_q <= 1'b0;
    end
    else if (ce)
    begin
      conv_start_q <= start_now;
      if (start_now)
        busy_q <= 1'b1;
      else if (conv_done || mode_d == CAM_SHELF || mode_d == CAM_OFF)
        busy_q <= 1'b0;
      // Sleep keeps analog off except during its one set of conversions
      analog_on_q <= (mode_d == CAM_RUN) || (mode_d == CAM_SAMPLE)
                   || ((mode_d == CAM_SSLEEP) && (start_now || (busy_q && !conv_done)));
    end
  end

  // ---------------------------------------------------------------
  // Accumulators and elapsed time counters
  // ---------------------------------------------------------------

  // Charge and discharge; time counters add one per conversion update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chg_acc_q <= 32'h00000000;
      dis_acc_q <= 32'h00000000;
      chg_time_q <= 32'h00000000;
      dis_time_q <= 32'h00000000;
    end
    else if (ce)
    begin
      if (chg_upd)
        chg_acc_q <= chg_acc_q + magnitude(results.current);
      if (dis_upd)
        dis_acc_q <= dis_acc_q + magnitude(results.current);
      if (update && cur_charge)
        chg_time_q <= chg_time_q + 32'h00000001;
      if (update && !cur_charge)
        dis_time_q <= dis_time_q + 32'h00000001;
    end
  end

  // Temperature and second-cell accumulators with their timers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temp_acc_q <= 32'h00000000;
      cell2_acc_q <= 32'h00000000;
      temp_time_q <= 32'h00000000;
      cell2_time_q <= 32'h00000000;
    end
    else if (ce)
    begin
      if (temp_upd)
      begin
        temp_acc_q <= temp_acc_q + magnitude(temp_src);
        temp_time_q <= temp_time_q + 32'h00000001;
      end
      if (cell2_upd)
      begin
        cell2_acc_q <= cell2_acc_q + magnitude(results.second_cell_result);
        cell2_time_q <= cell2_time_q + 32'h00000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_start = conv_start_q;
  assign analog_on = analog_on_q;
  assign temp_select_ext = acc_ctrl_q[ACC_TSEL_BIT];
  assign mode = mode_q;

endmodule : cam_top

`default_nettype wire

// File: verification/cam_top_properties.sv
// Concurrent checks on the cam_top ports.
// Assumes ce stays high; bound into every cam_top instance.
`default_nettype none
module cam_top_properties #(
  parameter int unsigned HALF_SEC_CYCLES = 20
)(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire cam_pkg::cam_trips_t trips, // Trip levels
  input wire logic conv_done, // Set finished
  input wire logic conv_start, // Set request
  input wire logic analog_on, // Analog power
  input wire logic temp_select_ext, // Temp source
  input wire cam_pkg::cam_mode_t mode // Power mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import cam_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Trip levels quiet, so that host writes alone steer the mode
  wire logic calm;
  assign calm = trips.pack_above_por && !trips.charge_above_trip && !trips.pack_above_sleep_trip;
  // A completed access, and a completed write to one offset
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_wr(logic [11:0] a);
    s_done ##0 pwrite && paddr == a && mode != CAM_SHELF;
  endsequence
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  a_map_error: assert property (s_done |-> pslverr == (paddr[1:0] != 2'h0 || paddr > OFS_CELL2_TIME))
    else $error("pslverr wrong");
  a_tsel_follow: assert property (s_wr(OFS_ACC_CTRL) |=> temp_select_ext == $past(pwdata[3]))
    else $error("temp select wrong");
  a_start_pulse: assert property (conv_start |=> !conv_start) else $error("conv_start held");
  // Busy drops on the answer edge, the next request is launched one edge later
  a_run_chain: assert property (conv_done && mode == CAM_RUN |=> ##1 (conv_start || mode != CAM_RUN))
    else $error("run not back to back");
  a_shelf_quiet: assert property (mode == CAM_SHELF |-> !conv_start && !analog_on)
    else $error("activity in shelf");
  a_host_sleep: assert property (s_wr(OFS_OP_MODE) ##0 pwdata[0] && calm |-> ##[1:3] mode == CAM_SSLEEP)
    else $error("sleep bit ignored");
endmodule : cam_top_properties
bind cam_top cam_top_properties #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) props (.*);
`default_nettype wire

// File: verification/cam_conv_model.sv
// Converter stand-in: latches the values to measure at each request and
// answers after LAT cycles; the result lines carry garbage between answers.
`default_nettype none
module cam_conv_model #(
  parameter int LAT = 3
)(
  input wire logic pclk, // Clock
  input wire logic conv_start, // Request pulse
  input wire cam_pkg::cam_results_t next_res, // Values to measure
  output logic conv_done, // Answer pulse
  output cam_pkg::cam_results_t results // Result lines
);
  timeunit 1ns;
  timeprecision 1ns;
  import cam_pkg::*;
  cam_results_t res_q = '0;
  int cnt = 0;
  initial conv_done = 1'b0;
  // Count down from a request, pulse the answer at the end
  always @(posedge pclk)
  begin
    conv_done <= (cnt == 1);
    cnt <= conv_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
    if (conv_start)
      res_q <= next_res;
  end
  // Sign-magnitude words, valid only while the answer stands
  assign results = conv_done ? res_q : ~res_q;
endmodule : cam_conv_model
`default_nettype wire

// File: verification/tb_cam_top.sv
// Self-checking bench for cam_top: APB registers, accumulation, power modes.
// Assumes the converter model and the bound checker sit beside the design.
`default_nettype none
module tb_cam_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cam_pkg::*;
  localparam int HALF = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tick = 1'b0, scl = 1'b1, sda = 1'b1, err, pready, pslverr, conv_done, conv_start, analog_on, tsel;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] exp[8] = '{default: 32'h0};
  logic [14:0] tm;
  logic [3:0] ctl = 4'h0;
  cam_results_t res, nres = '0;
  cam_trips_t trips = 7'h40;
  cam_mode_t mode;
  int n_fail = 0, num_checks = 0, ticks = 0, gap = 0;
  // Clock, and a watchdog well past the expected run length
  initial forever #50 pclk = ~pclk;
  initial
  begin
    #3000000;
    n_fail++;
    test_done;
  end
  cam_top #(.HALF_SEC_CYCLES(HALF)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .results(res), .trips(trips), .conv_done(conv_done), .rc_half_tick(tick),
    .scl_in(scl), .sda_in(sda), .conv_start(conv_start), .analog_on(analog_on), .temp_select_ext(tsel),
    .mode(mode));
  cam_conv_model conv (.pclk(pclk), .conv_start(conv_start), .next_res(nres), .conv_done(conv_done),
    .results(res));
  // Expected counters from each answer; enables follow completed writes
  always @(posedge pclk)
  begin
    if (conv_start)
      gap = ticks;
    ticks = conv_start ? 0 : ticks + tick;
    if (conv_done)
    begin
      exp[2 + res.current[15]] += 1;
      exp[res.current[15]] += ctl[0] ? res.current[14:0] : 15'h0;
      tm = ctl[3] ? res.external_temp_result[14:0] : res.internal_temp_result[14:0];
      exp[4] += (ctl[0] && ctl[1]) ? tm : 15'h0;
      exp[6] += {31'h0, ctl[0] && ctl[1]};
      exp[5] += (ctl[0] && ctl[2]) ? res.second_cell_result[14:0] : 15'h0;
      exp[7] += {31'h0, ctl[0] && ctl[2]};
    end
    if (psel && penable && pready && pwrite && paddr == OFS_ACC_CTRL)
      ctl = pwdata[3:0];
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  // One APB transfer, entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_mode(input cam_mode_t m, input int lim);
    for (int n = 0; n < lim && mode !== m; n++)
      @(posedge pclk);
    chk("mode", m, mode);
  endtask : wait_mode
  task automatic wait_start(output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (conv_start !== 1'b1 && n < 5000);
  endtask : wait_start
  task automatic t_accum;
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    nres <= {16'h0005, 16'h0003, 16'h8007, 16'h0002};
    apb(1'b1, OFS_ACC_CTRL, 32'h6);
    repeat (20) @(posedge pclk);
    apb(1'b1, OFS_ACC_CTRL, 32'h7);
    repeat (30) @(posedge pclk);
    nres <= {16'h8009, 16'h0003, 16'h8007, 16'h7FFF};
    apb(1'b1, OFS_ACC_CTRL, 32'hF);
    chk("temp_select_ext", 32'h1, {31'h0, tsel});
    repeat (30) @(posedge pclk);
    apb(1'b1, OFS_ACC_CTRL, 32'hB);
    repeat (20) @(posedge pclk);
    $display("t_accum end");
  endtask : t_accum
  task automatic t_sample;
    int n;
    apb(1'b1, OFS_CONV_CFG, 32'hF);
    wait_mode(CAM_SAMPLE, 3);
    repeat (3) wait_start(n);
    chk("sample period", 128 * HALF, n);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, OFS_CHG_ACC + 12'(4 * i), 32'h0);
      chk("counter", exp[i], rd);
    end
    $display("t_sample end");
  endtask : t_sample
  task automatic t_sleep;
    apb(1'b1, OFS_OP_MODE, 32'h1);
    wait_mode(CAM_SSLEEP, 3);
    apb(1'b1, OFS_CONV_CFG, 32'h2);
    repeat (10)
    begin
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      repeat (15) @(posedge pclk);
    end
    chk("sleep gap", 32'h2, gap);
    chk("analog_on", 32'h0, {31'h0, analog_on});
    apb(1'b1, OFS_OP_MODE, 32'h0);
    wait_mode(CAM_RUN, 3);
    $display("t_sleep end");
  endtask : t_sleep
  task automatic t_trips;
    apb(1'b1, OFS_TRIP_CTRL, 32'h5);
    trips <= 7'h68;
    repeat (10) @(posedge pclk);
    chk("mode", CAM_RUN, mode);
    trips <= 7'h60;
    wait_mode(CAM_SSLEEP, 4);
    trips <= 7'h48;
    wait_mode(CAM_RUN, 4);
    trips <= 7'h40;
    apb(1'b1, OFS_TRIP_CTRL, 32'h8);
    trips <= 7'h44;
    wait_mode(CAM_SSLEEP, 4);
    apb(1'b1, OFS_TRIP_CTRL, 32'h10);
    trips <= 7'h42;
    wait_mode(CAM_RUN, 4);
    trips <= 7'h40;
    $display("t_trips end");
  endtask : t_trips
  task automatic t_shelf;
    apb(1'b1, OFS_TRIP_CTRL, 32'h20);
    scl <= 1'b0;
    sda <= 1'b0;
    repeat (SHELF_DELAY_CYCLES - 10) @(posedge pclk);
    chk("mode", CAM_RUN, mode);
    wait_mode(CAM_SHELF, 20);
    apb(1'b0, OFS_ACC_CTRL, 32'h0);
    chk("shelf read", 32'h0, rd);
    scl <= 1'b1;
    sda <= 1'b1;
    repeat (WAKE_DELAY_CYCLES - 10) @(posedge pclk);
    chk("mode", CAM_SHELF, mode);
    wait_mode(CAM_RUN, 20);
    trips <= 7'h00;
    wait_mode(CAM_OFF, 3);
    $display("t_shelf end");
  endtask : t_shelf
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Reset for four cycles, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_mode(CAM_RUN, 5);
    t_accum;
    t_sample;
    t_sleep;
    t_trips;
    t_shelf;
    test_done;
  end
endmodule : tb_cam_top
`default_nettype wire
